// ### tccd_regs.svh
`ifndef TCCD_REGS_SVH
`define TCCD_REGS_SVH

// register offsets on the plain register port
`define TCCD_A_TRIB 3'h0
`define TCCD_A_ARG 3'h1
`define TCCD_A_FLAGS 3'h2
`define TCCD_A_KEY 3'h3
`define TCCD_A_STAT 3'h4
`define TCCD_A_RDAT 3'h5
`define TCCD_A_MODEM 3'h6
`define TCCD_A_TSTAT 3'h7

// request keys
`define TCCD_K_NOP 5'h00
`define TCCD_K_EST 5'h01
`define TCCD_K_DEL 5'h02
`define TCCD_K_START 5'h03
`define TCCD_K_MAINT 5'h04
`define TCCD_K_HALT 5'h05
`define TCCD_K_WMDM 5'h10
`define TCCD_K_RMDM 5'h11

// control flags byte positions
`define TCCD_F_POOL_EN 0
`define TCCD_F_POOL_DIS 1
`define TCCD_F_UNLATCH 4
`define TCCD_F_LATCH 5

// response codes
`define TCCD_RC_OK 8'h00
`define TCCD_RC_NO_TRIB 8'h01
`define TCCD_RC_FULL 8'h02
`define TCCD_RC_STATE 8'h03
`define TCCD_RC_BAD_KEY 8'h04
`define TCCD_RC_RUN 8'h10
`define TCCD_RC_POOL_BUSY 8'h5E
`define TCCD_IC_POOL_DONE 8'h01
`define TCCD_IC_MODEM 8'h02

// slot table geometry
`define TCCD_SLOTS 12
`define TCCD_SLOT_BYTES 64
`define TCCD_GLOBAL_ADDR 8'h00

`endif

// ### tccd_pkg.sv
package tccd_pkg;

  // link protocol state of one tributary
  typedef enum logic [1:0] {M_HALT, M_START, M_RUN, M_MAINT} tccd_mode_t;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_ARM, S_WAIT} tccd_fsm_t;

  // one tributary state block header
  typedef struct packed {
    logic valid;
    logic [7:0] tag;
    tccd_mode_t mode;
    logic pool_en;
    logic latched;
    logic [1:0] level;
  } tccd_trib_t;

  // control or information response
  typedef struct packed {
    logic valid;
    logic info;
    logic [7:0] trib;
    logic [7:0] code;
    logic [15:0] data;
  } tccd_rsp_t;

  // requests to the protocol engine
  typedef struct packed {
    logic start;
    logic halt_ret;
    logic pool_ret;
    logic [3:0] slot;
    logic [7:0] trib;
  } tccd_evt_t;

  // start-up finished report from the engine
  typedef struct packed {
    logic valid;
    logic [7:0] trib;
  } tccd_done_t;

  // protocol engine access to slot memory
  typedef struct packed {
    logic we;
    logic [3:0] slot;
    logic [5:0] idx;
    logic [7:0] wdata;
  } tccd_mem_req_t;

  typedef struct packed {
    logic busy;
    logic [3:0] slot;
    logic [5:0] idx;
    logic [7:0] rdata;
  } tccd_mem_state_t;

endpackage

// ### tccd_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "tccd_regs.svh"

module tccd_slot_mem import tccd_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic clr_go, // start wiping one slot
  input wire logic [3:0] clr_slot, // slot to wipe
  output logic clr_busy, // wipe in progress
  input wire tccd_mem_req_t req, // engine access
  output logic [7:0] rdata // engine read data
);

  tccd_mem_state_t s_reg, s_next;
  logic [7:0] mem [0:`TCCD_SLOTS*`TCCD_SLOT_BYTES-1];
  logic [9:0] waddr;
  logic [7:0] wdat;
  logic wen;

  // the wipe owns the write port; engine writes meanwhile are dropped
  always_comb begin
    wen = s_reg.busy | req.we;
    waddr = s_reg.busy ? {s_reg.slot, s_reg.idx} : {req.slot, req.idx};
    wdat = s_reg.busy ? 8'h00 : req.wdata;
  end

  // wipe sequencer, one byte per cycle
  always_comb begin
    s_next = s_reg;
    s_next.rdata = mem[{req.slot, req.idx}];
    if (s_reg.busy) begin
      s_next.idx = s_reg.idx + 6'h01;
      if (s_reg.idx == 6'h3F) begin
        s_next.busy = 1'b0;
      end
    end else if (clr_go) begin
      s_next.busy = 1'b1;
      s_next.slot = clr_slot;
      s_next.idx = 6'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // storage itself carries no reset
  always_ff @(posedge clk) begin
    if (wen) begin
      mem[waddr] <= wdat;
    end
  end

  assign clr_busy = s_reg.busy;
  assign rdata = s_reg.rdata;

endmodule
`default_nettype wire

// ### tccd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "tccd_regs.svh"

module tccd_decoder import tccd_pkg::*; (
  input wire logic clk, // 10 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [2:0] reg_addr, // register offset
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire tccd_done_t done, // engine: start-up finished
  output tccd_rsp_t rsp, // response, valid one cycle
  output tccd_evt_t evt, // engine requests, one cycle
  output logic [7:0] modem_out, // modem register
  output logic [11:0] poll_en, // slot may be polled
  output logic [11:0] maint_only, // slot in maintenance
  input wire tccd_mem_req_t mem_req, // engine slot memory access
  output logic [7:0] mem_rdata // slot memory read data
);

  typedef struct packed {
    tccd_fsm_t fsm;
    tccd_trib_t [`TCCD_SLOTS-1:0] trib;
    logic [7:0] taddr;
    logic [7:0] arg;
    logic [7:0] flags;
    logic [4:0] key;
    logic grant;
    logic [7:0] modem;
    logic [15:0] rdata;
    logic [15:0] rsp_data;
    logic [7:0] last_code;
    tccd_rsp_t rsp;
    tccd_evt_t evt;
    logic [11:0] poll_en;
    logic [11:0] maint;
    logic clr_go;
    logic [3:0] clr_slot;
    logic dpend;
    logic [7:0] dtrib;
  } tccd_state_t;

  tccd_state_t s_reg, s_next;
  logic [11:0] hv, fv, dv, pv;
  logic clr_busy;

  // per-slot address match, free slot, done match, pool users
  genvar g;
  generate
    for (g = 0; g < `TCCD_SLOTS; g++) begin : g_slot
      assign hv[g] = s_reg.trib[g].valid && s_reg.trib[g].tag == s_reg.taddr;
      assign fv[g] = !s_reg.trib[g].valid;
      assign dv[g] = s_reg.trib[g].valid && s_reg.trib[g].tag == s_reg.dtrib;
      assign pv[g] = s_reg.trib[g].valid && s_reg.trib[g].pool_en;
    end
  endgenerate

  // status storage of all slots; wiped on start-up
  tccd_slot_mem u_mem (
    .clk(clk),
    .rstn(rstn),
    .clr_go(s_reg.clr_go),
    .clr_slot(s_reg.clr_slot),
    .clr_busy(clr_busy),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  // command decode, slot bookkeeping and register port
  always_comb begin
    logic hit;
    logic dhit;
    logic ok;
    logic [3:0] hi;
    logic [3:0] fi;
    logic [3:0] di;
    logic [3:0] tgt;
    logic [3:0] cnt;
    logic [7:0] code;
    logic [15:0] rv;
    tccd_trib_t t;
    s_next = s_reg;
    hit = |hv;
    dhit = |dv;
    ok = 1'b0;
    hi = 4'h0;
    fi = 4'h0;
    di = 4'h0;
    tgt = 4'h0;
    cnt = 4'h0;
    code = `TCCD_RC_OK;
    rv = 16'h0000;
    t = '0;
    for (int i = `TCCD_SLOTS - 1; i >= 0; i--) begin
      if (hv[i]) hi = 4'(i);
      if (fv[i]) fi = 4'(i);
      if (dv[i]) di = 4'(i);
      if (s_reg.trib[i].valid) cnt = cnt + 4'h1;
    end
    s_next.rsp.valid = 1'b0;
    s_next.evt = '0;
    s_next.clr_go = 1'b0;
    // a new report wins over the clear of the pending one
    if (done.valid) begin
      s_next.dtrib = done.trib;
    end
    case (s_reg.fsm)
      S_IDLE: begin
        // run state report, only while no command is in flight
        if (s_reg.dpend) begin
          s_next.dpend = done.valid;
          if (dhit && s_reg.trib[di].mode == M_START) begin
            s_next.trib[di].mode = M_RUN;
            s_next.rsp = '{1'b1, 1'b0, s_reg.dtrib, `TCCD_RC_RUN,
                           16'h0000};
          end
        end
        if (reg_wr && s_reg.grant) begin
          case (reg_addr)
            `TCCD_A_TRIB: s_next.taddr = reg_wdata[7:0];
            `TCCD_A_ARG: s_next.arg = reg_wdata[7:0];
            `TCCD_A_FLAGS: s_next.flags = reg_wdata[7:0];
            `TCCD_A_KEY: begin
              // writing the key issues the command
              s_next.key = reg_wdata[4:0];
              s_next.grant = 1'b0;
              s_next.fsm = S_EXEC;
            end
            default: ;
          endcase
        end
      end
      S_EXEC: begin
        s_next.fsm = S_IDLE;
        s_next.grant = 1'b1;
        ok = hit;
        tgt = hi;
        case (s_reg.key)
          `TCCD_K_NOP: ;
          `TCCD_K_EST: begin
            // an existing tag is kept, so re-establish is harmless
            if (!hit) begin
              if (&(~fv)) begin
                code = `TCCD_RC_FULL;
              end else begin
                t.valid = 1'b1;
                t.tag = s_reg.taddr;
                t.mode = M_HALT;
                s_next.trib[fi] = t;
                tgt = fi;
                ok = 1'b1;
              end
            end
          end
          `TCCD_K_DEL: begin
            if (!hit) begin
              code = `TCCD_RC_NO_TRIB;
            end else if (s_reg.trib[hi].mode != M_HALT) begin
              code = `TCCD_RC_STATE;
            end else begin
              s_next.trib[hi] = '0;
              ok = 1'b0;
            end
          end
          `TCCD_K_START: begin
            if (!hit) begin
              code = `TCCD_RC_NO_TRIB;
            end else if (s_reg.trib[hi].mode != M_HALT) begin
              code = `TCCD_RC_STATE;
            end else begin
              // host waits out the 64-cycle wipe before its next command
              s_next.trib[hi].mode = M_START;
              s_next.clr_go = 1'b1;
              s_next.clr_slot = hi;
              s_next.evt.start = 1'b1;
              s_next.fsm = S_ARM;
              s_next.grant = 1'b0;
            end
          end
          `TCCD_K_MAINT: begin
            if (!hit) begin
              code = `TCCD_RC_NO_TRIB;
            end else if (s_reg.trib[hi].mode != M_HALT) begin
              code = `TCCD_RC_STATE;
            end else begin
              s_next.trib[hi].mode = M_MAINT;
            end
          end
          `TCCD_K_HALT: begin
            if (s_reg.taddr == `TCCD_GLOBAL_ADDR) begin
              ok = 1'b0;
              if (|pv) begin
                code = `TCCD_RC_POOL_BUSY;
              end else begin
                s_next.evt.pool_ret = 1'b1;
                s_next.rsp = '{1'b1, 1'b1, s_reg.taddr,
                               `TCCD_IC_POOL_DONE, 16'h0000};
              end
            end else if (!hit) begin
              code = `TCCD_RC_NO_TRIB;
            end else begin
              // slot bytes stay untouched here; a later restart wipes them
              s_next.trib[hi].mode = M_HALT;
              s_next.evt.halt_ret = 1'b1;
            end
          end
          `TCCD_K_WMDM: s_next.modem = s_reg.arg;
          `TCCD_K_RMDM: begin
            s_next.rsp_data = {8'h00, s_reg.modem};
            s_next.rsp = '{1'b1, 1'b1, s_reg.taddr, `TCCD_IC_MODEM,
                           {8'h00, s_reg.modem}};
          end
          default: code = `TCCD_RC_BAD_KEY;
        endcase
        // pool and latch flags ride along with any key that succeeds on a live or new slot, except delete and global halt
        if (code == `TCCD_RC_OK &&
            (s_reg.flags[`TCCD_F_POOL_EN] || s_reg.flags[`TCCD_F_POOL_DIS] ||
             s_reg.flags[`TCCD_F_LATCH] || s_reg.flags[`TCCD_F_UNLATCH])) begin
          if (!ok) begin
            code = `TCCD_RC_NO_TRIB;
          end else begin
            if (s_reg.flags[`TCCD_F_POOL_EN]) begin
              s_next.trib[tgt].pool_en = 1'b1;
            end
            // disable wins when both are set
            if (s_reg.flags[`TCCD_F_POOL_DIS]) begin
              s_next.trib[tgt].pool_en = 1'b0;
            end
            if (s_reg.flags[`TCCD_F_UNLATCH]) begin
              s_next.trib[tgt].latched = 1'b0;
              s_next.trib[tgt].level = 2'b00;
            end
            if (s_reg.flags[`TCCD_F_LATCH]) begin
              s_next.trib[tgt].latched = 1'b1;
              s_next.trib[tgt].level = s_reg.arg[1:0];
            end
          end
        end
        if (code != `TCCD_RC_OK) begin
          s_next.rsp = '{1'b1, 1'b0, s_reg.taddr, code, 16'h0000};
        end
        s_next.last_code = code;
        s_next.evt.slot = tgt;
        s_next.evt.trib = s_reg.taddr;
      end
      S_ARM: s_next.fsm = S_WAIT;
      S_WAIT: begin
        if (!clr_busy) begin
          s_next.grant = 1'b1;
          s_next.fsm = S_IDLE;
        end
      end
      default: s_next.fsm = S_IDLE;
    endcase
    if (done.valid) begin
      s_next.dpend = 1'b1;
    end
    if (s_next.rsp.valid && s_next.rsp.info) begin
      s_next.rsp_data = s_next.rsp.data;
    end
    // halted or absent slots are taken out of the poll list
    for (int i = 0; i < `TCCD_SLOTS; i++) begin
      s_next.poll_en[i] = s_next.trib[i].valid &&
                          s_next.trib[i].mode != M_HALT;
      s_next.maint[i] = s_next.trib[i].valid &&
                        s_next.trib[i].mode == M_MAINT;
    end
    // read data only in the cycle after the strobe
    case (reg_addr)
      `TCCD_A_TRIB: rv = {8'h00, s_reg.taddr};
      `TCCD_A_ARG: rv = {8'h00, s_reg.arg};
      `TCCD_A_FLAGS: rv = {8'h00, s_reg.flags};
      `TCCD_A_STAT: rv = {s_reg.last_code, 2'b00, cnt, |(~fv),
                          s_reg.grant};
      `TCCD_A_RDAT: rv = s_reg.rsp_data;
      `TCCD_A_MODEM: rv = {8'h00, s_reg.modem};
      `TCCD_A_TSTAT: rv = hit ? {7'h00, s_reg.trib[hi].valid,
                                 s_reg.trib[hi].mode,
                                 s_reg.trib[hi].pool_en,
                                 s_reg.trib[hi].latched, 2'b00,
                                 s_reg.trib[hi].level} : 16'h0000;
      default: rv = 16'h0000;
    endcase
    s_next.rdata = reg_rd ? rv : 16'h0000;
  end

  // grant is up from reset: the host may issue at once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.grant <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign rsp = s_reg.rsp;
  assign evt = s_reg.evt;
  assign modem_out = s_reg.modem;
  assign poll_en = s_reg.poll_en;
  assign maint_only = s_reg.maint;

endmodule
`default_nettype wire

// ### tccd_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tccd_regs.svh"

module tccd_decoder_checker import tccd_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [2:0] reg_addr, // register offset
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire tccd_done_t done, // start-up finished
  input wire tccd_rsp_t rsp, // response
  input wire tccd_evt_t evt, // engine requests
  input wire logic [7:0] modem_out, // modem register
  input wire logic [11:0] poll_en, // slot may be polled
  input wire logic [11:0] maint_only // slot in maintenance
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a request key write and its key field
  logic key_wr;
  logic [4:0] key;
  assign key_wr = reg_wr && reg_addr == `TCCD_A_KEY;
  assign key = reg_wdata[4:0];

  a_nop_no_evt: assert property (key_wr && key == `TCCD_K_NOP |-> ##2
    !(evt.start || evt.halt_ret || evt.pool_ret)) else $error("nop made evt");
  a_modem_cause: assert property ($changed(modem_out) |->
    $past(key_wr && key == `TCCD_K_WMDM, 2)) else $error("modem moved");
  a_rmodem_info: assert property (key_wr && key == `TCCD_K_RMDM |-> ##2
    rsp.valid && rsp.info && rsp.data == {8'h00, modem_out})
    else $error("read modem response wrong");
  a_start_cause: assert property (evt.start |->
    $past(key_wr && key == `TCCD_K_START, 2)) else $error("stray start");
  a_halt_cause: assert property (evt.halt_ret || evt.pool_ret |->
    $past(key_wr && key == `TCCD_K_HALT, 2)) else $error("stray return");
  a_halt_unpolled: assert property (evt.halt_ret |->
    !poll_en[evt.slot]) else $error("halted slot still polled");
  a_maint_cause: assert property ((maint_only & ~$past(maint_only)) !=
    12'h000 |-> $past(key_wr && key == `TCCD_K_MAINT, 2))
    else $error("stray maintenance");
  a_run_report: assert property (done.valid |-> ##[1:100]
    rsp.valid && rsp.code == `TCCD_RC_RUN) else $error("no run response");
endmodule

bind tccd_decoder tccd_decoder_checker i_tccd_decoder_checker (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .done(done), .rsp(rsp), .evt(evt),
  .modem_out(modem_out), .poll_en(poll_en), .maint_only(maint_only)
);
`default_nettype wire

// ### tccd_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module tccd_engine_model import tccd_pkg::*; #(
  parameter int DLY = 20,
  parameter logic [7:0] MARK = 8'h5a
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire tccd_evt_t evt, // requests from the decoder
  output var tccd_done_t done, // start-up finished pulse
  output var tccd_mem_req_t mem_req // slot memory port
);
  int cnt;
  logic [7:0] trib;

  // start-up exchange stand-in: fixed delay, then one report
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      trib <= 8'h00;
      done <= '0;
    end else begin
      done <= '0;
      if (evt.start) begin
        cnt <= DLY;
        trib <= evt.trib;
      end else if (cnt == 1) begin
        done.valid <= 1'b1;
        done.trib <= trib;
        cnt <= 0;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // marks byte 0 of a halted slot, then keeps reading it back
  // so a wipe or a lost slot shows on the read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_req <= '0;
    end else begin
      mem_req.we <= evt.halt_ret;
      if (evt.halt_ret) begin
        mem_req.slot <= evt.slot;
        mem_req.idx <= 6'h00;
        mem_req.wdata <= MARK;
      end
    end
  end
endmodule
`default_nettype wire

// ### tccd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tccd_regs.svh"

module tccd_decoder_tb import tccd_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, d;
  logic [7:0] modem_out, mem_rdata;
  logic [11:0] poll_en, maint_only;
  tccd_done_t done;
  tccd_rsp_t rsp, last_rsp;
  tccd_evt_t evt;
  tccd_mem_req_t mem_req;
  int mismatches = 0;
  int comparisons = 0;
  // byte the engine model leaves in a slot it has halted
  localparam logic [7:0] MARK = 8'h5a;

  // 10 MHz
  initial begin
    forever #50 clk = ~clk;
  end

  tccd_decoder i_tccd_decoder (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .done(done), .rsp(rsp),
    .evt(evt), .modem_out(modem_out), .poll_en(poll_en),
    .maint_only(maint_only), .mem_req(mem_req), .mem_rdata(mem_rdata));

  tccd_engine_model #(.MARK(MARK)) i_tccd_engine_model (.clk(clk),
    .rstn(rstn), .evt(evt), .done(done), .mem_req(mem_req));

  // responses are single pulses, so keep the latest one
  always @(posedge clk) begin
    if (rsp.valid === 1'b1) last_rsp <= rsp;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  function automatic logic [17:0] rc(input logic i, input logic [7:0] t,
                                     input logic [7:0] c);
    return {1'b1, i, t, c};
  endfunction

  // issue one command, wait for the grant, then compare any response
  task automatic cmd(input logic [7:0] t, input logic [7:0] a,
                     input logic [7:0] f, input logic [4:0] k,
                     input logic [17:0] exp);
    logic [15:0] s;
    last_rsp = '0;
    wr(`TCCD_A_TRIB, {8'h00, t});
    wr(`TCCD_A_ARG, {8'h00, a});
    wr(`TCCD_A_FLAGS, {8'h00, f});
    wr(`TCCD_A_KEY, {11'h000, k});
    s = 16'h0000;
    for (int i = 0; i < 300 && s[0] !== 1'b1; i++) rd(`TCCD_A_STAT, s);
    for (int i = 0; i < 100 && last_rsp.valid !== 1'b1; i++) @(posedge clk);
    chk(last_rsp[33:16], exp);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang must not outlive the longest plausible run
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(`TCCD_A_STAT, d);
    chk(d, 16'h0001);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_NOP, 18'h0);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_START, rc(0, 5, `TCCD_RC_NO_TRIB));
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_EST, 18'h0);
    rd(`TCCD_A_STAT, d);
    chk(d[7:0], 8'h07);
    // pool enable plus latch at level two beside the null key
    cmd(8'h05, 8'h02, 8'h21, `TCCD_K_NOP, 18'h0);
    rd(`TCCD_A_TSTAT, d);
    chk(d, 16'h0132);
    cmd(8'h00, 8'h00, 8'h00, `TCCD_K_HALT, rc(0, 0, `TCCD_RC_POOL_BUSY));
    // pool disable plus unlatch clears what the first flags set
    cmd(8'h05, 8'h00, 8'h12, `TCCD_K_NOP, 18'h0);
    rd(`TCCD_A_TSTAT, d);
    chk(d, 16'h0100);
    cmd(8'h00, 8'h00, 8'h00, `TCCD_K_HALT, rc(1, 0, `TCCD_IC_POOL_DONE));
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_START, rc(0, 5, `TCCD_RC_RUN));
    rd(`TCCD_A_TSTAT, d);
    chk(d[8:6], 3'b110);
    chk(poll_en, 12'h001);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_DEL, rc(0, 5, `TCCD_RC_STATE));
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_MAINT, rc(0, 5, `TCCD_RC_STATE));
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_HALT, 18'h0);
    rd(`TCCD_A_TSTAT, d);
    chk(d[8:6], 3'b100);
    chk(mem_rdata, MARK);
    chk(poll_en, 12'h000);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_MAINT, 18'h0);
    chk(|maint_only, 1'b1);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_HALT, 18'h0);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_DEL, 18'h0);
    rd(`TCCD_A_TSTAT, d);
    chk(d, 16'h0000);
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_EST, 18'h0);
    rd(`TCCD_A_TSTAT, d);
    chk(d, 16'h0100);
    // restart wipes the marker left by the last halt
    cmd(8'h05, 8'h00, 8'h00, `TCCD_K_START, rc(0, 5, `TCCD_RC_RUN));
    chk(mem_rdata, 8'h00);
    // fill the table, then one address too many
    for (int t = 1; t <= 12; t++) begin
      cmd(8'(t), 8'h00, 8'h00, `TCCD_K_EST, 18'h0);
    end
    cmd(8'h0d, 8'h00, 8'h00, `TCCD_K_EST, rc(0, 13, `TCCD_RC_FULL));
    rd(`TCCD_A_STAT, d);
    chk(d[7:0], 8'h33);
    cmd(8'h01, 8'ha5, 8'h00, `TCCD_K_WMDM, 18'h0);
    chk(modem_out, 8'ha5);
    cmd(8'h01, 8'h00, 8'h00, `TCCD_K_RMDM, rc(1, 1, `TCCD_IC_MODEM));
    rd(`TCCD_A_RDAT, d);
    chk(d, 16'h00a5);
    tally_and_finish;
  end
endmodule
`default_nettype wire
